/* File: lighting_ctrl_regs_b.sv */
// lighting control register group with serial slave and flash control
// Summary of operation
// - boost frequency: 1xx gives 2.00 MHz, 01x 1.67 MHz, 00x 1.00 MHz
// - safety enable bit limits the flash on-time
// - external pwm gate bit lets the pwm input chop the flash
// - duration codes 00/01/10 hold flash 200/400/600 ms
// - duration code 11 keeps flash on while the flash pin is high
// - flash current code selects quarter steps of full current
// - flash enable bit switches the flash driver on or off
// - blink start bit runs or stops the blinking sequences
// - run bit starts the pattern from command one, clear stops it
// - repeat bit clear runs once, set loops until stopped
// - curve bit picks intensity mapping mode 0 or 1
// - group one red/green/blue caps in bits 5-4, 3-2, 1-0
// - group two caps use the same steps and positions
// - audio gain code steps 3 dB from 0 to 21 dB
// - filter bit picks amplitude (0) or frequency (1) mode
// - agc bit enables automatic audio gain adjustment
// - sync bit enables audio-driven color control
// - input select: audio, temperature, light, none (reset value)
`timescale 1ns/100ps
module lighting_ctrl_regs_b
  import light_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h2C,  // arbitrary bus address
  parameter int         FL_T0_CYC = FLASH_T0_CYC,
  parameter int         FL_T1_CYC = FLASH_T1_CYC,
  parameter int         FL_T2_CYC = FLASH_T2_CYC,
  parameter int         SAFE_CYC  = SAFETY_CYC
) (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  nrst,
  // serial control pins
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  // flash pins
  input  wire logic  flash_pin,
  input  wire logic  flash_external_pwm_gate,
  output logic       flash_drive,
  output logic [1:0] flash_current_level,
  // boost converter
  output boost_freq_t boost_freq_sel,
  // pattern generator
  input  wire logic  pattern_end,
  output logic       blink_run,
  output logic       pattern_run,
  output logic       pattern_start,
  output logic       pattern_loop,
  output logic       intensity_curve,
  // color driver current caps
  output logic [1:0] red_one_current_cap,
  output logic [1:0] green_one_current_cap,
  output logic [1:0] blue_one_current_cap,
  output logic [1:0] red_two_current_cap,
  output logic [1:0] green_two_current_cap,
  output logic [1:0] blue_two_current_cap,
  // audio sync and converter
  output logic [2:0] audio_gain_sel,
  output logic       audio_filter_freq,
  output logic       audio_agc_en,
  output logic       audio_sync_en,
  output logic [1:0] adc_input_sel
);

  typedef struct packed {
    ser_st_t    st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       rw;
    logic       oe;
    logic       scl_q;
    logic       sda_q;
    logic       pin_q;
    logic       run_q;
    logic [2:0] boost;
    logic [6:0] flash;
    logic [3:0] pat;
    logic [5:0] cap1;
    logic [5:0] cap2;
    logic [7:0] audio;
  } state_t;

  state_t cur_ff;
  state_t nxt_st;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_now;

  flash_timer_if ft ();

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input state_t s);
    case (a)
      OFS_BOOST: rd_byte = {5'h00, s.boost};
      OFS_FLASH: rd_byte = {1'b0, s.flash};
      OFS_PAT:   rd_byte = {4'h0, s.pat};
      OFS_CAP1:  rd_byte = {2'h0, s.cap1};
      OFS_CAP2:  rd_byte = {2'h0, s.cap2};
      OFS_AUDIO: rd_byte = s.audio;
      default:   rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // boost frequency decode, low bit never matters
  function automatic boost_freq_t freq_dec(input logic [2:0] f);
    if (f[2]) begin
      freq_dec = FREQ_2M00;
    end else if (f[1]) begin
      freq_dec = FREQ_1M67;
    end else begin
      freq_dec = FREQ_1M00;
    end
  endfunction : freq_dec

  // ----------------------------------------------------------------
  // serial line events
  // ----------------------------------------------------------------
  assign scl_rise  = scl_in && !cur_ff.scl_q;
  assign scl_fall  = !scl_in && cur_ff.scl_q;
  assign bus_start = scl_in && cur_ff.scl_q && cur_ff.sda_q && !sda_in;
  assign bus_stop  = scl_in && cur_ff.scl_q && !cur_ff.sda_q && sda_in;
  assign wr_en     = cur_ff.st == S_WDAT && scl_fall &&
                     cur_ff.bit_cnt == 4'h8;
  assign wr_addr   = cur_ff.ptr;
  assign wr_data   = cur_ff.shreg;
  assign rd_now    = rd_byte(cur_ff.ptr, cur_ff);

  // next state: serial slave, register writes, pattern control
  always_comb begin
    nxt_st       = cur_ff;
    nxt_st.scl_q = scl_in;
    nxt_st.sda_q = sda_in;
    nxt_st.pin_q = flash_pin;
    nxt_st.run_q = cur_ff.pat[PT_RUN];
    if (bus_start) begin
      nxt_st.st      = S_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.oe      = 1'b0;
    end else if (bus_stop) begin
      nxt_st.st = S_IDLE;
      nxt_st.oe = 1'b0;
    end else begin
      case (cur_ff.st)
        S_IDLE: begin
          nxt_st.oe = 1'b0;
        end
        S_ADDR, S_PTR, S_WDAT: begin
          if (scl_rise) begin
            nxt_st.shreg   = {cur_ff.shreg[6:0], sda_in};
            nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
          end else if (scl_fall && cur_ff.bit_cnt == 4'h8) begin
            nxt_st.oe = 1'b1;
            case (cur_ff.st)
              S_ADDR: begin
                nxt_st.rw = cur_ff.shreg[0];
                if (cur_ff.shreg[7:1] == DEV_ADDR) begin
                  nxt_st.st = S_AACK;
                end else begin
                  nxt_st.st = S_IDLE;
                  nxt_st.oe = 1'b0;
                end
              end
              S_PTR: begin
                nxt_st.ptr = cur_ff.shreg;
                nxt_st.st  = S_PACK;
              end
              default: begin
                nxt_st.ptr = cur_ff.ptr + 8'h01;
                nxt_st.st  = S_WACK;
              end
            endcase
          end
        end
        S_AACK, S_PACK, S_WACK: begin
          if (scl_fall) begin
            nxt_st.bit_cnt = 4'h0;
            if (cur_ff.st == S_AACK && cur_ff.rw) begin
              nxt_st.shreg = rd_now;
              nxt_st.ptr   = cur_ff.ptr + 8'h01;
              nxt_st.oe    = !rd_now[7];
              nxt_st.st    = S_RDAT;
            end else begin
              nxt_st.oe = 1'b0;
              nxt_st.st = (cur_ff.st == S_AACK) ? S_PTR : S_WDAT;
            end
          end
        end
        S_RDAT: begin
          if (scl_fall) begin
            if (cur_ff.bit_cnt == 4'h7) begin
              nxt_st.oe = 1'b0;
              nxt_st.st = S_RACK;
            end else begin
              nxt_st.bit_cnt = cur_ff.bit_cnt + 4'h1;
              nxt_st.shreg   = {cur_ff.shreg[6:0], 1'b0};
              nxt_st.oe      = !cur_ff.shreg[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise && sda_in) begin
            nxt_st.st = S_IDLE;                 // master said no more
          end else if (scl_fall) begin
            nxt_st.shreg   = rd_now;
            nxt_st.ptr     = cur_ff.ptr + 8'h01;
            nxt_st.oe      = !rd_now[7];
            nxt_st.bit_cnt = 4'h0;
            nxt_st.st      = S_RDAT;
          end
        end
        default: begin
          nxt_st.st = S_IDLE;
          nxt_st.oe = 1'b0;
        end
      endcase
    end
    // single-shot pattern ends by itself, a write in the same cycle wins
    if (pattern_end && !cur_ff.pat[PT_LOOP]) begin
      nxt_st.pat[PT_RUN] = 1'b0;
    end
    // register writes keep only implemented bits
    if (wr_en) begin
      case (wr_addr)
        OFS_BOOST: nxt_st.boost = wr_data[2:0];
        OFS_FLASH: nxt_st.flash = wr_data[6:0];
        OFS_PAT:   nxt_st.pat   = wr_data[3:0];
        OFS_CAP1:  nxt_st.cap1  = wr_data[5:0];
        OFS_CAP2:  nxt_st.cap2  = wr_data[5:0];
        OFS_AUDIO: nxt_st.audio = wr_data;
        default:   nxt_st.ptr   = nxt_st.ptr;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff       <= '0;
      cur_ff.st    <= S_IDLE;
      cur_ff.scl_q <= 1'b1;
      cur_ff.sda_q <= 1'b1;
      cur_ff.boost <= BOOST_RST;
      cur_ff.flash <= FLASH_RST;
      cur_ff.pat   <= PAT_RST;
      cur_ff.cap1  <= CAP_RST;
      cur_ff.cap2  <= CAP_RST;
      cur_ff.audio <= AUDIO_RST;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // flash control
  // ----------------------------------------------------------------
  assign ft.trig      = cur_ff.flash[FL_EN] && flash_pin && !cur_ff.pin_q;
  assign ft.abort     = !cur_ff.flash[FL_EN];
  assign ft.hold_mode = cur_ff.flash[FL_DUR +: 2] == DUR_PIN;
  assign ft.pin_level = flash_pin;
  assign ft.safety_en = cur_ff.flash[FL_SAFE];
  assign ft.dur_code  = cur_ff.flash[FL_DUR +: 2];

  flash_timer #(
    .CNT_W (TMR_W),
    .T0    (FL_T0_CYC),
    .T1    (FL_T1_CYC),
    .T2    (FL_T2_CYC),
    .TSAFE (SAFE_CYC)
  ) u_flash_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ft       (ft)
  );

  // flash output gated by enable and optional external pwm
  assign flash_drive = ft.active && cur_ff.flash[FL_EN] &&
                       (!cur_ff.flash[FL_PWM] ||
                        flash_external_pwm_gate);
  assign flash_current_level = cur_ff.flash[FL_LVL +: 2];

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  assign sda_out         = 1'b0;
  assign sda_oe          = cur_ff.oe;
  assign boost_freq_sel  = freq_dec(cur_ff.boost);
  assign blink_run       = cur_ff.pat[PT_BLINK];
  assign pattern_run     = cur_ff.pat[PT_RUN];
  assign pattern_start   = cur_ff.pat[PT_RUN] && !cur_ff.run_q;
  assign pattern_loop    = cur_ff.pat[PT_LOOP];
  assign intensity_curve = cur_ff.pat[PT_LOG];

  // per-channel caps, same layout in both groups
  assign red_one_current_cap   = cur_ff.cap1[CAP_R +: 2];
  assign green_one_current_cap = cur_ff.cap1[CAP_G +: 2];
  assign blue_one_current_cap  = cur_ff.cap1[CAP_B +: 2];
  assign red_two_current_cap   = cur_ff.cap2[CAP_R +: 2];
  assign green_two_current_cap = cur_ff.cap2[CAP_G +: 2];
  assign blue_two_current_cap  = cur_ff.cap2[CAP_B +: 2];

  // audio and converter setup
  assign audio_gain_sel    = cur_ff.audio[AU_GAIN +: 3];
  assign audio_filter_freq = cur_ff.audio[AU_MODE];
  assign audio_agc_en      = cur_ff.audio[AU_AGC];
  assign audio_sync_en     = cur_ff.audio[AU_SYNC];
  assign adc_input_sel     = cur_ff.audio[AU_SEL +: 2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_boost_freq_wr: assert property (
    wr_en && wr_addr == OFS_BOOST |=>
      boost_freq_sel == (wr_data[2] ? FREQ_2M00 :
                         wr_data[1] ? FREQ_1M67 : FREQ_1M00))
    else $error("boost frequency does not follow write");
  a_pwm_no_effect: assert property (
    $past(flash_drive) && ft.active && cur_ff.flash[FL_EN] &&
    !cur_ff.flash[FL_PWM] && $fell(flash_external_pwm_gate)
      |-> flash_drive)
    else $error("pwm gated flash while gating disabled");
  a_flash_off_wr: assert property (
    wr_en && wr_addr == OFS_FLASH && !wr_data[FL_EN]
      |=> !flash_drive ##1 !ft.active)
    else $error("flash not stopped by disable");
  a_pattern_start: assert property (
    wr_en && wr_addr == OFS_PAT && wr_data[PT_RUN] && !pattern_run
      |=> pattern_start ##1 !pattern_start)
    else $error("pattern start pulse missing");
  a_single_stop: assert property (
    pattern_end && !pattern_loop && !(wr_en && wr_addr == OFS_PAT)
      |=> !pattern_run)
    else $error("single pattern did not stop");
  a_reserved_zero: assert property (
    wr_en && wr_addr == OFS_CAP1 |=> rd_byte(OFS_CAP1, cur_ff)
      == {2'h0, wr_data[5:0]})
    else $error("reserved bits not zero after write");

endmodule : lighting_ctrl_regs_b

/* File: light_regs_pkg.sv */
// shared constants and types for the lighting control register group
package light_regs_pkg;

  // ----------------------------------------------------------------
  // clock and flash timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 40_000;
  localparam int FLASH_T0_MS  = 200;
  localparam int FLASH_T1_MS  = 400;
  localparam int FLASH_T2_MS  = 600;
  localparam int SAFETY_MS    = 1000;
  localparam int FLASH_T0_CYC = FLASH_T0_MS * CLK_KHZ;
  localparam int FLASH_T1_CYC = FLASH_T1_MS * CLK_KHZ;
  localparam int FLASH_T2_CYC = FLASH_T2_MS * CLK_KHZ;
  localparam int SAFETY_CYC   = SAFETY_MS * CLK_KHZ;
  localparam int TMR_W        = 26;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_BOOST = 8'h0E;
  localparam logic [7:0] OFS_FLASH = 8'h10;
  localparam logic [7:0] OFS_PAT   = 8'h11;
  localparam logic [7:0] OFS_CAP1  = 8'h12;
  localparam logic [7:0] OFS_CAP2  = 8'h13;
  localparam logic [7:0] OFS_AUDIO = 8'h2A;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] BOOST_RST = 3'h7;
  localparam logic [6:0] FLASH_RST = 7'h00;
  localparam logic [3:0] PAT_RST   = 4'h0;
  localparam logic [5:0] CAP_RST   = 6'h00;
  localparam logic [7:0] AUDIO_RST = 8'h03;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FL_EN    = 0;
  localparam int FL_LVL   = 1;
  localparam int FL_DUR   = 3;
  localparam int FL_PWM   = 5;
  localparam int FL_SAFE  = 6;
  localparam int PT_LOG   = 0;
  localparam int PT_LOOP  = 1;
  localparam int PT_RUN   = 2;
  localparam int PT_BLINK = 3;
  localparam int CAP_R    = 4;
  localparam int CAP_G    = 2;
  localparam int CAP_B    = 0;
  localparam int AU_GAIN  = 5;
  localparam int AU_MODE  = 4;
  localparam int AU_AGC   = 3;
  localparam int AU_SYNC  = 2;
  localparam int AU_SEL   = 0;
  localparam logic [1:0] DUR_PIN = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FREQ_1M00 = 2'b00,
    FREQ_1M67 = 2'b01,
    FREQ_2M00 = 2'b10
  } boost_freq_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ADDR  = 4'b0001,
    S_AACK  = 4'b0010,
    S_PTR   = 4'b0011,
    S_PACK  = 4'b0100,
    S_WDAT  = 4'b0101,
    S_WACK  = 4'b0110,
    S_RDAT  = 4'b0111,
    S_RACK  = 4'b1000
  } ser_st_t;

endpackage : light_regs_pkg

/* File: flash_timer_if.sv */
// signals between the register group and the flash timer
`timescale 1ns/100ps
interface flash_timer_if;
  logic       trig;
  logic       abort;
  logic       hold_mode;
  logic       pin_level;
  logic       safety_en;
  logic [1:0] dur_code;
  logic       active;
  modport ctrl  (output trig, abort, hold_mode, pin_level, safety_en,
                 dur_code, input active);
  modport timer (input trig, abort, hold_mode, pin_level, safety_en,
                 dur_code, output active);
endinterface : flash_timer_if

/* File: flash_timer.sv */
// flash on-time counter with fixed, pin-held and safety limits
`timescale 1ns/100ps
module flash_timer
  import light_regs_pkg::*;
#(
  parameter int CNT_W = TMR_W,
  parameter int T0    = FLASH_T0_CYC,
  parameter int T1    = FLASH_T1_CYC,
  parameter int T2    = FLASH_T2_CYC,
  parameter int TSAFE = SAFETY_CYC
) (
  // clock and reset
  input wire logic   core_clk,
  input wire logic   nrst,
  // control side
  flash_timer_if.timer ft
);

  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] cnt;
  } tmr_t;

  tmr_t cur_ff;
  tmr_t nxt_tmr;
  logic [CNT_W-1:0] lim;

  // ----------------------------------------------------------------
  // fixed duration per code
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] dur_lim(input logic [1:0] c);
    case (c)
      2'h0:    dur_lim = CNT_W'(T0);
      2'h1:    dur_lim = CNT_W'(T1);
      default: dur_lim = CNT_W'(T2);
    endcase
  endfunction : dur_lim

  assign lim       = dur_lim(ft.dur_code);
  assign ft.active = cur_ff.active;

  // next state: start on trigger, stop on first limit reached
  always_comb begin
    nxt_tmr = cur_ff;
    if (!cur_ff.active) begin
      nxt_tmr.cnt = '0;
      if (ft.trig && !ft.abort) begin
        nxt_tmr.active = 1'b1;
      end
    end else begin
      nxt_tmr.cnt = cur_ff.cnt + 1'b1;
      if (ft.abort) begin
        nxt_tmr.active = 1'b0;
      end else if (ft.hold_mode && !ft.pin_level) begin
        nxt_tmr.active = 1'b0;
      end else if (!ft.hold_mode && cur_ff.cnt >= lim - 1'b1) begin
        nxt_tmr.active = 1'b0;
      end else if (ft.safety_en &&
                   cur_ff.cnt >= CNT_W'(TSAFE - 1)) begin
        nxt_tmr.active = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_tmr;
    end
  end

  default clocking tcb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_safety_cap: assert property (
    cur_ff.active && ft.safety_en |-> cur_ff.cnt < CNT_W'(TSAFE))
    else $error("flash ran past safety limit");
  a_fixed_end: assert property (
    cur_ff.active && !ft.hold_mode && !ft.abort &&
    cur_ff.cnt == lim - 1'b1 |=> !cur_ff.active)
    else $error("fixed flash time not ended");
  a_pin_release: assert property (
    cur_ff.active && ft.hold_mode && !ft.pin_level |=> !cur_ff.active)
    else $error("flash kept on after pin release");

endmodule : flash_timer

/* File: host_ser_model.sv */
// serial host model driving the register bus of the lighting block
`timescale 1ns/100ps
module host_ser_model (
  // clock and device side
  input  wire logic core_clk,
  input  wire logic sda_oe,
  // bus lines
  output logic      scl,
  output logic      sda_m,
  output logic      sda_w
);
  // wire level: pulled up unless a party pulls low
  assign sda_w = sda_m & ~sda_oe;
  // idle bus at time zero
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // wait n clocks, then step off the edge
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tk
  // start or repeated start
  task automatic start;
    sda_m = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(3);
    sda_m = 1'b0;
    tk(3);
    scl = 1'b0;
    tk(2);
  endtask : start
  // stop, bus left idle
  task automatic stop;
    sda_m = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(3);
    sda_m = 1'b1;
    tk(3);
  endtask : stop
  // one bit: sda set in scl low, sampled late in scl high
  task automatic cyc1(input logic b, output logic r);
    sda_m = b;
    tk(2);
    scl = 1'b1;
    tk(4);
    r = sda_w;
    scl = 1'b0;
    tk(2);
  endtask : cyc1
  // one byte msb first, then the acknowledge slot
  task automatic xb(input logic [7:0] d, input logic last,
                    output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) cyc1(d[i], r[i]);
    cyc1(last, a);
  endtask : xb
endmodule : host_ser_model

/* File: lighting_ctrl_regs_b_bench.sv */
// self-checking bench for the lighting control register group
`timescale 1ns/100ps
module lighting_ctrl_regs_b_bench;
  import light_regs_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h2C;
  logic        core_clk  = 1'b0;
  logic        nrst      = 1'b0;
  logic        flash_pin = 1'b0;
  logic        pwm_in    = 1'b0;
  logic        pwm_run   = 1'b0;
  logic        pat_end   = 1'b0;
  logic        scl, sda_m, sda_w, sda_oe, drv;
  logic [1:0]  lvl, r1, g1, b1, r2, g2, b2, sel;
  logic        blink, run, st_p, loop_o, curve, filt, agc, sync;
  logic [2:0]  gain;
  logic [7:0]  rx;
  boost_freq_t bsel;
  int          miscompares = 0;
  int          comparisons = 0;
  int          on_cnt = 0;
  int          starts = 0;
  // ------------------------------------------------------------
  // instances and clock
  // ------------------------------------------------------------
  host_ser_model host_ser_model_i (.core_clk(core_clk), .sda_oe(sda_oe),
    .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
  lighting_ctrl_regs_b #(.DEV_ADDR(DEV), .FL_T0_CYC(20), .FL_T1_CYC(40),
    .FL_T2_CYC(60), .SAFE_CYC(100)) lighting_ctrl_regs_b_i (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(), .sda_oe(sda_oe), .flash_pin(flash_pin),
    .flash_external_pwm_gate(pwm_in), .flash_drive(drv),
    .flash_current_level(lvl), .boost_freq_sel(bsel),
    .pattern_end(pat_end), .blink_run(blink), .pattern_run(run),
    .pattern_start(st_p), .pattern_loop(loop_o), .intensity_curve(curve),
    .red_one_current_cap(r1), .green_one_current_cap(g1),
    .blue_one_current_cap(b1), .red_two_current_cap(r2),
    .green_two_current_cap(g2), .blue_two_current_cap(b2),
    .audio_gain_sel(gain), .audio_filter_freq(filt), .audio_agc_en(agc),
    .audio_sync_en(sync), .adc_input_sel(sel));
  always #12.5 core_clk = ~core_clk;
  // count flash on-cycles and pattern start pulses
  always @(posedge core_clk) begin
    if (drv === 1'b1) on_cnt++;
    if (st_p === 1'b1) starts++;
  end
  // external pwm toggles every cycle while a scenario runs it
  always @(posedge core_clk) begin
    if (pwm_run) #2 pwm_in = ~pwm_in;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tick;
    @(posedge core_clk);
    #2;
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    host_ser_model_i.start;
    host_ser_model_i.xb({DEV, 1'b0}, 1'b1, rx);
    host_ser_model_i.xb(ofs, 1'b1, rx);
    host_ser_model_i.xb(d, 1'b1, rx);
    host_ser_model_i.stop;
    tick;
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    host_ser_model_i.start;
    host_ser_model_i.xb({DEV, 1'b0}, 1'b1, rx);
    host_ser_model_i.xb(ofs, 1'b1, rx);
    host_ser_model_i.start;
    host_ser_model_i.xb({DEV, 1'b1}, 1'b1, rx);
    host_ser_model_i.xb(8'hFF, 1'b1, rx);
    host_ser_model_i.stop;
    chk(rx, exp);
  endtask : rd
  task automatic fl(input logic [7:0] v, input int hold, lo, hi);
    wr(8'h10, v);
    on_cnt = 0;
    flash_pin = 1'b1;
    repeat (hold) tick;
    flash_pin = 1'b0;
    repeat (90) tick;
    chk({7'h00, on_cnt >= lo && on_cnt <= hi}, 8'h01);
  endtask : fl
  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h0E, 8'h07);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h2A, 8'h03);
    rd(8'h20, 8'h00);
  endtask : t_reset
  task automatic t_boost;
    wr(8'h0E, 8'hFF);
    rd(8'h0E, 8'h07);
    for (int c = 0; c < 8; c++) begin
      wr(8'h0E, 8'(c));
      chk({6'h00, bsel}, c > 3 ? 8'h02 : (c > 1 ? 8'h01 : 8'h00));
    end
  endtask : t_boost
  task automatic t_caps;
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h3F);
    chk({2'h0, r1, g1, b1}, 8'h3F);
    wr(8'h13, 8'hDB);
    chk({2'h0, r2, g2, b2}, 8'h1B);
  endtask : t_caps
  task automatic t_audio;
    wr(8'h2A, 8'hB4);
    rd(8'h2A, 8'hB4);
    chk({gain, filt, agc, sync, sel}, 8'hB4);
    chk({7'h00, sync}, 8'h01);
    wr(8'h2A, 8'h4B);
    chk({gain, filt, agc, sync, sel}, 8'h4B);
    wr(8'h2A, 8'h02);
    chk({6'h00, sel}, 8'h02);
  endtask : t_audio
  task automatic t_pattern;
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h0F);
    chk({2'h0, blink, run, loop_o, curve, 2'h0}, 8'h3C);
    wr(8'h11, 8'h08);
    chk({4'h0, blink, run, loop_o, curve}, 8'h08);
    wr(8'h11, 8'h05);
    chk({4'h0, blink, run, loop_o, curve}, 8'h05);
    chk(8'(starts), 8'h02);
    pat_end = 1'b1;
    tick;
    pat_end = 1'b0;
    tick;
    chk({7'h00, run}, 8'h00);
    wr(8'h11, 8'h06);
    pat_end = 1'b1;
    tick;
    pat_end = 1'b0;
    tick;
    chk({6'h00, run, loop_o}, 8'h03);
  endtask : t_pattern
  task automatic t_flash;
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, 8'(k << 1));
      chk({6'h00, lvl}, 8'(k));
    end
    fl(8'h05, 3, 20, 20);
    fl(8'h0D, 3, 40, 40);
    fl(8'h15, 3, 60, 60);
    fl(8'h04, 3, 0, 0);
    fl(8'h25, 3, 0, 0);
    fl(8'h1D, 30, 28, 32);
    fl(8'h1D, 150, 148, 152);
    fl(8'h5D, 150, 98, 102);
  endtask : t_flash
  task automatic t_pwm;
    pwm_run = 1'b1;
    fl(8'h25, 3, 10, 10);
    fl(8'h05, 3, 20, 20);
    pwm_run = 1'b0;
  endtask : t_pwm
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    tick;
    t_reset;
    t_boost;
    t_caps;
    t_audio;
    t_pattern;
    t_flash;
    t_pwm;
    summarize;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    summarize;
  end
endmodule : lighting_ctrl_regs_b_bench
